/* File: uart_paged_register_decoder_bench.sv */
// uart_paged_register_decoder_bench.sv: self-checking bench of the paged decoder
// assumes: uprd_host model drives the host side; expectations come from a mirror of the pages
`timescale 1ns/1ps
module uart_paged_register_decoder_bench;
  import uprd_pkg::*;
  logic         sys_clk = 1'b0;
  logic         resetn  = 1'b0;
  uprd_acc_s    acc;
  uprd_stat_s   stat;
  logic [7:0]   rdata, tx_data, fifo_ctrl, line_control, modem_control, int_enable;
  logic         rvalid, tx_load, fifo_ctrl_load, rx_pop;
  logic         int_status_read, line_status_read, modem_status_read;
  logic [15:0]  divisor;
  logic [2:0]   page;
  int           bad_count  = 0;
  int           num_checks = 0;
  logic [15:0]  seed       = 16'd28924;
  logic [7:0]   mem [0:39];
  logic [7:0]   lcr_m, tx_m, fc_m;

  always #4 sys_clk = ~sys_clk;

  uprd_host h (.SYS_CLK(sys_clk), .ACC(acc), .STAT(stat));
  uprd_decoder dut (.SYS_CLK(sys_clk), .RESETN(resetn), .ACC(acc), .STAT(stat),
    .RDATA(rdata), .RVALID(rvalid), .TX_DATA(tx_data), .TX_LOAD(tx_load),
    .FIFO_CTRL(fifo_ctrl), .FIFO_CTRL_LOAD(fifo_ctrl_load), .RX_POP(rx_pop),
    .INT_STATUS_READ(int_status_read), .LINE_STATUS_READ(line_status_read),
    .MODEM_STATUS_READ(modem_status_read), .DIVISOR(divisor),
    .LINE_CONTROL(line_control), .MODEM_CONTROL(modem_control),
    .INT_ENABLE(int_enable), .PAGE(page));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {1'b0, x[15:1]} ^ (x[0] ? 16'hB400 : 16'h0000);
  endfunction
  function automatic logic [2:0] cur_page();
    if (lcr_m == 8'hBF) return mem[24][0] ? 3'h4 : 3'h3;
    if (lcr_m[7]) return 3'h1;
    return mem[4][6] ? 3'h2 : 3'h0;
  endfunction
  // slots shared between pages fold onto one mirror entry
  function automatic int key(input logic [2:0] pg, input logic [2:0] o);
    if (pg <= 3'h2 && o == 3'h4) return 4;
    if (pg == 3'h1 && o == 3'h7) return 7;
    if (pg == 3'h4 && o == 3'h0) return 24;
    return int'(pg) * 8 + int'(o);
  endfunction
  function automatic logic writable(input logic [2:0] pg, input logic [2:0] o);
    return !((pg <= 3'h1 && (o == 3'h2 || o == 3'h5 || o == 3'h6)) ||
             (pg == 3'h0 && o == 3'h0) || (pg == 3'h2 && o != 3'h4));
  endfunction
  function automatic logic [7:0] exp_rd(input logic [2:0] pg, input logic [2:0] o,
                                        input uprd_stat_s st);
    if (o == 3'h3) return lcr_m;
    if (pg == 3'h0 && o == 3'h0) return st.rx_buffer;
    if (pg <= 3'h1 && o == 3'h2) return st.int_status;
    if (pg <= 3'h1 && o == 3'h5) return st.line_status;
    if (pg <= 3'h1 && o == 3'h6) return st.modem_status;
    if (pg == 3'h2 && o == 3'h5) return st.tx_fifo_level;
    if (pg == 3'h2 && o == 3'h6) return st.rx_fifo_level;
    if (pg == 3'h2 && o == 3'h7) return st.flow_status;
    if (pg == 3'h2 && o != 3'h4) return 8'h00;
    return mem[key(pg, o)];
  endfunction

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected read data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected register output at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pulse(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected strobe set at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [2:0] o, input logic rd, input logic [7:0] d);
    logic [2:0] pg;
    uprd_stat_s st;
    logic [7:0] er;
    logic [6:0] ep;
    pg   = cur_page();
    seed = lfsr(seed);
    st   = {seed, seed ^ 16'h5A3C, seed ^ 16'hC3A5, seed[15:8]};
    er   = exp_rd(pg, o, st);
    ep   = {rd, !rd && pg == 3'h0 && o == 3'h0, !rd && pg <= 3'h1 && o == 3'h2,
            rd && pg == 3'h0 && o == 3'h0, rd && pg <= 3'h1 && o == 3'h2,
            rd && pg <= 3'h1 && o == 3'h5, rd && pg <= 3'h1 && o == 3'h6};
    h.put(o, rd, d, st);
    if (!rd && o == 3'h3) lcr_m = d;
    else if (!rd && writable(pg, o)) mem[key(pg, o)] = d;
    if (!rd && pg == 3'h0 && o == 3'h0) tx_m = d;
    if (!rd && pg <= 3'h1 && o == 3'h2) fc_m = d;
    chk_reg(16'(page), 16'(pg));
    chk_pulse(16'({rvalid, tx_load, fifo_ctrl_load, rx_pop, int_status_read,
                   line_status_read, modem_status_read}), 16'(ep));
    if (rd) chk_data(16'(rdata), 16'(er));
    chk_reg(divisor, {mem[9], mem[8]});
    chk_reg(16'(line_control), 16'(lcr_m));
    chk_reg(16'(modem_control), 16'(mem[4]));
    chk_reg(16'(int_enable), 16'(mem[1]));
    chk_reg({tx_data, fifo_ctrl}, {tx_m, fc_m});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    results();
  end

  // selector values that bring up pages 0 to 4 in turn
  logic [7:0] lcr_tab [0:4] = '{8'h00, 8'h80, 8'h00, 8'hBF, 8'hBF};
  logic [2:0] sel_ofs [0:4] = '{3'h4, 3'h3, 3'h4, 3'h0, 3'h0};
  logic [7:0] sel_val [0:4] = '{8'h00, 8'h80, 8'h40, 8'h00, 8'h01};
  initial begin
    logic [7:0] d;
    for (int i = 0; i < 40; i++) mem[i] = 8'h00;
    lcr_m = 8'h00;
    tx_m  = 8'h00;
    fc_m  = 8'h00;
    repeat (5) @(posedge sys_clk);
    #1 resetn = 1'b1;
    for (int p = 0; p < 5; p++) begin
      op(3'h3, 1'b0, lcr_tab[p]);
      op(sel_ofs[p], 1'b0, sel_val[p]);
      for (int o = 0; o < 8; o++) begin
        seed = lfsr(seed);
        d    = seed[7:0];
        if (o == 4 && p <= 2) d[6] = (p == 2);
        if (o == 0 && p >= 3) d[0] = (p == 4);
        if (o != 3) op(3'(o), 1'b0, d);
      end
      for (int o = 0; o < 8; o++) op(3'(o), 1'b1, 8'h00);
    end
    for (int n = 0; n < 400; n++) begin
      seed = lfsr(seed);
      op(seed[2:0], seed[3], (seed[2:0] == 3'h3 && seed[4]) ? 8'hBF : seed[15:8]);
    end
    h.idle();
    results();
  end
endmodule

/* File: uprd_cfg.svh */
// uprd_cfg.svh: offsets, selector values, reset values and field positions of the paged decoder
// assumes: included by the design modules, not by the package
`ifndef UPRD_CFG_SVH
`define UPRD_CFG_SVH
`define UPRD_OFS_0        3'h0
`define UPRD_OFS_1        3'h1
`define UPRD_OFS_2        3'h2
`define UPRD_OFS_3        3'h3
`define UPRD_OFS_4        3'h4
`define UPRD_OFS_5        3'h5
`define UPRD_OFS_6        3'h6
`define UPRD_OFS_7        3'h7
`define UPRD_LCR_EXT_KEY  8'hBF
`define UPRD_DLAB_BIT     7
`define UPRD_PG2_BIT      6
`define UPRD_PSEL_BIT     0
`define UPRD_RST_BYTE     8'h00
`endif

/* File: uprd_decoder.sv */
// uprd_decoder.sv: paged register decoder for one serial channel
// assumes: host strobes are synchronous one-cycle pulses; status bytes come from the channel core
`timescale 1ns/1ps
`include "uprd_cfg.svh"
module uprd_decoder (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RESETN,
  input  wire uprd_pkg::uprd_acc_s  ACC,
  input  wire uprd_pkg::uprd_stat_s STAT,
  output logic [7:0]                RDATA,
  output logic                      RVALID,
  output logic [7:0]                TX_DATA,
  output logic                      TX_LOAD,
  output logic [7:0]                FIFO_CTRL,
  output logic                      FIFO_CTRL_LOAD,
  output logic                      RX_POP,
  output logic                      INT_STATUS_READ,
  output logic                      LINE_STATUS_READ,
  output logic                      MODEM_STATUS_READ,
  output logic [15:0]               DIVISOR,
  output logic [7:0]                LINE_CONTROL,
  output logic [7:0]                MODEM_CONTROL,
  output logic [7:0]                INT_ENABLE,
  output logic [2:0]                PAGE
);
  import uprd_pkg::*;

  logic [7:0] int_enable_ff;
  logic [7:0] line_control_ff;
  logic [7:0] modem_control_ff;
  logic [7:0] scratch_pad_ff;
  logic [7:0] divisor_low_ff;
  logic [7:0] divisor_high_ff;
  logic [7:0] page_select_ff;
  logic [7:0] auto_toggle_ctrl_ff;
  logic [7:0] enhanced_feature_ff;
  logic [7:0] flow_resume_char1_ff;
  logic [7:0] flow_resume_char2_ff;
  logic [7:0] flow_stop_char1_ff;
  logic [7:0] flow_stop_char2_ff;
  logic [7:0] additional_feature_ff;
  logic [7:0] flow_stop_resend_count_ff;
  logic [7:0] tx_fifo_trigger_ff;
  logic [7:0] rx_fifo_trigger_ff;
  logic [7:0] flow_upper_threshold_ff;
  logic [7:0] flow_lower_threshold_ff;
  logic [7:0] rdata_ff;
  logic       rvalid_ff;
  logic [7:0] tx_data_ff;
  logic       tx_load_ff;
  logic [7:0] fifo_ctrl_ff;
  logic       fifo_ctrl_load_ff;
  logic       rx_pop_ff;
  logic       isr_rd_ff;
  logic       lsr_rd_ff;
  logic       msr_rd_ff;
  logic [2:0] page_ff;

  uprd_page_e page;
  logic       p0;
  logic       p1;
  logic       p2;
  logic       p3;
  logic       p4;
  logic       p01;
  logic       p34;
  logic [7:0] o;
  logic       wr;
  logic       rd;
  logic [7:0] wd;

  uprd_page_sel u_page_sel (
    .line_control  (line_control_ff),
    .modem_control (modem_control_ff),
    .page_select   (page_select_ff),
    .page          (page)
  );

  assign p0  = (page == UPRD_PG0);
  assign p1  = (page == UPRD_PG1);
  assign p2  = (page == UPRD_PG2);
  assign p3  = (page == UPRD_PG3);
  assign p4  = (page == UPRD_PG4);
  assign p01 = p0 | p1;
  assign p34 = p3 | p4;
  assign wr  = ACC.wr;
  assign rd  = ACC.rd;
  assign wd  = ACC.wdata;

  // one-hot offset decode
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_ofs
      assign o[gi] = (ACC.ofs == 3'(gi));
    end
  endgenerate

  // write enables per register
  logic we_thr;
  logic we_ier;
  logic we_fcr;
  logic we_lcr;
  logic we_mcr;
  logic we_spr;
  logic we_dll;
  logic we_dlm;
  logic we_psr;
  logic we_atr;
  logic we_efr;
  logic we_xn1;
  logic we_xn2;
  logic we_xf1;
  logic we_xf2;
  logic we_afr;
  logic we_xrc;
  logic we_ttr;
  logic we_rtr;
  logic we_fur;
  logic we_flr;
  assign we_thr = wr & p0 & o[`UPRD_OFS_0];
  assign we_ier = wr & p0 & o[`UPRD_OFS_1];
  assign we_fcr = wr & p01 & o[`UPRD_OFS_2];
  assign we_lcr = wr & o[`UPRD_OFS_3];
  assign we_mcr = wr & ~p34 & o[`UPRD_OFS_4];
  assign we_spr = wr & p01 & o[`UPRD_OFS_7];
  assign we_dll = wr & p1 & o[`UPRD_OFS_0];
  assign we_dlm = wr & p1 & o[`UPRD_OFS_1];
  assign we_psr = wr & p34 & o[`UPRD_OFS_0];
  assign we_atr = wr & p3 & o[`UPRD_OFS_1];
  assign we_efr = wr & p3 & o[`UPRD_OFS_2];
  assign we_xn1 = wr & p3 & o[`UPRD_OFS_4];
  assign we_xn2 = wr & p3 & o[`UPRD_OFS_5];
  assign we_xf1 = wr & p3 & o[`UPRD_OFS_6];
  assign we_xf2 = wr & p3 & o[`UPRD_OFS_7];
  assign we_afr = wr & p4 & o[`UPRD_OFS_1];
  assign we_xrc = wr & p4 & o[`UPRD_OFS_2];
  assign we_ttr = wr & p4 & o[`UPRD_OFS_4];
  assign we_rtr = wr & p4 & o[`UPRD_OFS_5];
  assign we_fur = wr & p4 & o[`UPRD_OFS_6];
  assign we_flr = wr & p4 & o[`UPRD_OFS_7];

  // read mux; status offsets on pages 0,1 read the channel core, page 2 holes at offsets 0 to 2 fall to zero
  logic [7:0] rmux;
  always_comb begin
    rmux = `UPRD_RST_BYTE;
    unique case (ACC.ofs)
      `UPRD_OFS_0: begin
        if (p0) rmux = STAT.rx_buffer;
        else if (p1) rmux = divisor_low_ff;
        else if (p34) rmux = page_select_ff;
      end
      `UPRD_OFS_1: begin
        if (p0) rmux = int_enable_ff;
        else if (p1) rmux = divisor_high_ff;
        else if (p3) rmux = auto_toggle_ctrl_ff;
        else if (p4) rmux = additional_feature_ff;
      end
      `UPRD_OFS_2: begin
        if (p01) rmux = STAT.int_status;
        else if (p3) rmux = enhanced_feature_ff;
        else if (p4) rmux = flow_stop_resend_count_ff;
      end
      `UPRD_OFS_3: rmux = line_control_ff;
      `UPRD_OFS_4: begin
        if (!p34) rmux = modem_control_ff;
        else if (p3) rmux = flow_resume_char1_ff;
        else rmux = tx_fifo_trigger_ff;
      end
      `UPRD_OFS_5: begin
        if (p01) rmux = STAT.line_status;
        else if (p2) rmux = STAT.tx_fifo_level;
        else if (p3) rmux = flow_resume_char2_ff;
        else rmux = rx_fifo_trigger_ff;
      end
      `UPRD_OFS_6: begin
        if (p01) rmux = STAT.modem_status;
        else if (p2) rmux = STAT.rx_fifo_level;
        else if (p3) rmux = flow_stop_char1_ff;
        else rmux = flow_upper_threshold_ff;
      end
      `UPRD_OFS_7: begin
        if (p01) rmux = scratch_pad_ff;
        else if (p2) rmux = STAT.flow_status;
        else if (p3) rmux = flow_stop_char2_ff;
        else rmux = flow_lower_threshold_ff;
      end
    endcase
  end

  // read side effects reported to the channel core
  logic nxt_rx_pop;
  logic nxt_isr_rd;
  logic nxt_lsr_rd;
  logic nxt_msr_rd;
  assign nxt_rx_pop = rd & p0 & o[`UPRD_OFS_0];
  assign nxt_isr_rd = rd & p01 & o[`UPRD_OFS_2];
  assign nxt_lsr_rd = rd & p01 & o[`UPRD_OFS_5];
  assign nxt_msr_rd = rd & p01 & o[`UPRD_OFS_6];

  // generic storage byte with write enable
  `define UPRD_REG(q, we) \
    always_ff @(posedge SYS_CLK or negedge RESETN) begin \
      if (!RESETN) q <= `UPRD_RST_BYTE; \
      else if (we) q <= wd; \
    end

  `UPRD_REG(int_enable_ff, we_ier)
  `UPRD_REG(line_control_ff, we_lcr)
  `UPRD_REG(modem_control_ff, we_mcr)
  `UPRD_REG(scratch_pad_ff, we_spr)
  `UPRD_REG(divisor_low_ff, we_dll)
  `UPRD_REG(divisor_high_ff, we_dlm)
  `UPRD_REG(page_select_ff, we_psr)
  `UPRD_REG(auto_toggle_ctrl_ff, we_atr)
  `UPRD_REG(enhanced_feature_ff, we_efr)
  `UPRD_REG(flow_resume_char1_ff, we_xn1)
  `UPRD_REG(flow_resume_char2_ff, we_xn2)
  `UPRD_REG(flow_stop_char1_ff, we_xf1)
  `UPRD_REG(flow_stop_char2_ff, we_xf2)
  `UPRD_REG(additional_feature_ff, we_afr)
  `UPRD_REG(flow_stop_resend_count_ff, we_xrc)
  `UPRD_REG(tx_fifo_trigger_ff, we_ttr)
  `UPRD_REG(rx_fifo_trigger_ff, we_rtr)
  `UPRD_REG(flow_upper_threshold_ff, we_fur)
  `UPRD_REG(flow_lower_threshold_ff, we_flr)
  `UPRD_REG(tx_data_ff, we_thr)
  `UPRD_REG(fifo_ctrl_ff, we_fcr)

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff          <= `UPRD_RST_BYTE;
      rvalid_ff         <= 1'b0;
      tx_load_ff        <= 1'b0;
      fifo_ctrl_load_ff <= 1'b0;
      rx_pop_ff         <= 1'b0;
      isr_rd_ff         <= 1'b0;
      lsr_rd_ff         <= 1'b0;
      msr_rd_ff         <= 1'b0;
      page_ff           <= 3'h0;
    end else begin
      if (rd) rdata_ff <= rmux;
      rvalid_ff         <= rd;
      tx_load_ff        <= we_thr;
      fifo_ctrl_load_ff <= we_fcr;
      rx_pop_ff         <= nxt_rx_pop;
      isr_rd_ff         <= nxt_isr_rd;
      lsr_rd_ff         <= nxt_lsr_rd;
      msr_rd_ff         <= nxt_msr_rd;
      page_ff           <= 3'(page);
    end
  end

  assign RDATA             = rdata_ff;
  assign RVALID            = rvalid_ff;
  assign TX_DATA           = tx_data_ff;
  assign TX_LOAD           = tx_load_ff;
  assign FIFO_CTRL         = fifo_ctrl_ff;
  assign FIFO_CTRL_LOAD    = fifo_ctrl_load_ff;
  assign RX_POP            = rx_pop_ff;
  assign INT_STATUS_READ   = isr_rd_ff;
  assign LINE_STATUS_READ  = lsr_rd_ff;
  assign MODEM_STATUS_READ = msr_rd_ff;
  assign DIVISOR           = {divisor_high_ff, divisor_low_ff};
  assign LINE_CONTROL      = line_control_ff;
  assign MODEM_CONTROL     = modem_control_ff;
  assign INT_ENABLE        = int_enable_ff;
  assign PAGE              = page_ff;

  // checks
  a_lcr_any_page: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ACC.wr && ACC.ofs == 3'h3 |=> line_control_ff == $past(ACC.wdata))
    else $error("line control write lost");
  a_mcr_ext_lock: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ACC.wr && ACC.ofs == 3'h4 && line_control_ff == 8'hBF |=> $stable(modem_control_ff))
    else $error("modem control written under key");
  a_thr_load: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ACC.wr && ACC.ofs == 3'h0 && page == UPRD_PG0 |=> TX_LOAD && TX_DATA == $past(ACC.wdata))
    else $error("transmit load missing");
  a_dll_write: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ACC.wr && ACC.ofs == 3'h0 && page == UPRD_PG1 |=> DIVISOR[7:0] == $past(ACC.wdata) && !TX_LOAD)
    else $error("divisor low write wrong");
  a_scratch_back: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ACC.rd && ACC.ofs == 3'h7 && p01 |=> RDATA == scratch_pad_ff)
    else $error("scratch readback wrong");
  a_pg2_hole: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ACC.rd && p2 && ACC.ofs < 3'h3 |=> RDATA == 8'h00)
    else $error("page 2 hole not zero");
  a_lsr_ro: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ACC.rd && p01 && ACC.ofs == 3'h5 |=> RDATA == $past(STAT.line_status) && LINE_STATUS_READ)
    else $error("line status read wrong");
  a_page_pick: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    line_control_ff == 8'hBF |-> page == (page_select_ff[0] ? UPRD_PG4 : UPRD_PG3))
    else $error("key page select wrong");
  c_page4_write: cover property (@(posedge SYS_CLK) disable iff (!RESETN) we_flr);
  c_page2_read: cover property (@(posedge SYS_CLK) disable iff (!RESETN) rd && p2 && o[7]);
  c_divisor_write: cover property (@(posedge SYS_CLK) disable iff (!RESETN) we_dlm);
endmodule

/* File: uprd_host.sv */
// uprd_host.sv: host side model, drives register accesses and channel status bytes
// assumes: one access per clock, launched 1 ns after the rising edge of SYS_CLK
`timescale 1ns/1ps
module uprd_host (
  input  wire logic          SYS_CLK,
  output uprd_pkg::uprd_acc_s  ACC,
  output uprd_pkg::uprd_stat_s STAT
);
  import uprd_pkg::*;
  initial begin
    ACC  = '0;
    STAT = '0;
  end
  // access taken at the next edge; strobe stays up so the next call runs back to back
  task automatic put(input logic [2:0] ofs, input logic rd, input logic [7:0] d,
                     input uprd_stat_s st);
    ACC  = '{ofs: ofs, rd: rd, wr: !rd, wdata: d};
    STAT = st;
    @(posedge SYS_CLK);
    #1;
  endtask
  // released data no longer shows the last byte
  task automatic idle();
    ACC = '{ofs: ~ACC.ofs, rd: 1'b0, wr: 1'b0, wdata: ~ACC.wdata};
    @(posedge SYS_CLK);
    #1;
  endtask
endmodule

/* File: uprd_page_sel.sv */
// uprd_page_sel.sv: picks the active register page from line control, modem control, page select
// assumes: inputs are register contents of the same clock domain
`timescale 1ns/1ps
`include "uprd_cfg.svh"
module uprd_page_sel (
  input  wire logic [7:0]         line_control,
  input  wire logic [7:0]         modem_control,
  input  wire logic [7:0]         page_select,
  output uprd_pkg::uprd_page_e    page
);
  import uprd_pkg::*;
  logic ext_key;
  logic dlab;
  logic pg2;
  assign ext_key = (line_control == `UPRD_LCR_EXT_KEY);
  assign dlab    = line_control[`UPRD_DLAB_BIT];
  assign pg2     = modem_control[`UPRD_PG2_BIT];
  // key wins over divisor access, then page-two select
  assign page = ext_key ? (page_select[`UPRD_PSEL_BIT] ? UPRD_PG4 : UPRD_PG3) :
                dlab    ? UPRD_PG1 :
                pg2     ? UPRD_PG2 :
                          UPRD_PG0;
endmodule

/* File: uprd_pkg.sv */
// uprd_pkg.sv: types shared by the paged decoder and its page selector
// assumes: uprd_cfg.svh is on the include path
package uprd_pkg;
  typedef enum logic [2:0] {
    UPRD_PG0,
    UPRD_PG1,
    UPRD_PG2,
    UPRD_PG3,
    UPRD_PG4
  } uprd_page_e;

  typedef struct packed {
    logic [2:0] ofs;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } uprd_acc_s;

  typedef struct packed {
    logic [7:0] tx_fifo_level;
    logic [7:0] rx_fifo_level;
    logic [7:0] flow_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [7:0] int_status;
    logic [7:0] rx_buffer;
  } uprd_stat_s;
endpackage
